// file: logic/dwp_cfg.svh
/*
  register offsets, field positions, reset values, bit masks and the homing flag limit of the
  drive warning and parameter bank. assumes inclusion by bare name only.
*/
`ifndef DWP_CFG_SVH
`define DWP_CFG_SVH

// parameter addresses as seen by the fieldbus master
`define DWP_OFS_USER_A 16'h013E
`define DWP_OFS_USER_B 16'h0140
`define DWP_OFS_USER_C 16'h0142
`define DWP_OFS_USER_D 16'h0144
`define DWP_OFS_ABS_HOME 16'h062C
`define DWP_OFS_LIVE_WARN 16'h1C16
`define DWP_OFS_STICKY_WARN 16'h1C18
`define DWP_OFS_VOLT_USE 16'h1E26

// factory values
`define DWP_RST_USER 32'h0000_0000
`define DWP_RST_ABS_HOME 1'h0
`define DWP_RST_WARN 16'h0000

// warning bit positions
`define DWP_BIT_GENERAL 0
`define DWP_BIT_STAGE_TEMP 1
`define DWP_BIT_MOTOR_TEMP 2
`define DWP_BIT_STAGE_OVLD 4
`define DWP_BIT_BRAKE_OVLD 6
`define DWP_BIT_CAN 7
`define DWP_BIT_ENCODER 8
`define DWP_BIT_RS485 9
`define DWP_BIT_SAFE_TORQUE_OFF 10
`define DWP_BIT_UNDERVOLT 11
`define DWP_BIT_FIELDBUS 12
`define DWP_BIT_POS_INVALID 13
`define DWP_BIT_ETHERNET 14

// defined warning bits (3, 5 and 15 read zero) and self-clearing bits
`define DWP_WARN_VALID_MASK 16'h7FD7
`define DWP_WARN_AUTO_MASK 16'h2C00

// largest value the homing flag accepts
`define DWP_ABS_HOME_MAX 32'h0000_0001

`endif

// file: logic/dwp_pkg.sv
/*
  types shared by the drive warning and parameter bank.
  assumes dwp_cfg.svh is on the include path.
*/
package dwp_pkg;
  typedef logic [15:0] dwp_addr_t;
  typedef logic [31:0] dwp_word_t;
  typedef logic [15:0] dwp_warn_t;
  typedef logic signed [15:0] dwp_pct_t;
  // access port answer state, one-hot
  typedef enum logic [1:0] {
    DWP_IDLE = 2'b01,
    DWP_ANSWER = 2'b10
  } dwp_state_t;
endpackage : dwp_pkg

// file: logic/dwp_warn_if.sv
/*
  carrier between the bank and its warning latch.
  assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface dwp_warn_if;
  import dwp_pkg::*;
  dwp_warn_t cond; // warning conditions, already masked
  logic fault_reset; // fault reset pulse
  dwp_warn_t live; // registered live warnings
  dwp_warn_t latched; // registered sticky warnings
  modport latch (input cond, input fault_reset, output live, output latched);
  modport bank (output cond, output fault_reset, input live, input latched);
endinterface : dwp_warn_if

// file: logic/dwp_warn_latch.sv
/*
  live and sticky class 0 warning words, one slice per bit.
  assumes conditions are synchronous to sys_clk and pre-masked.
*/
`timescale 1ns/1ps
`include "dwp_cfg.svh"
module dwp_warn_latch (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  dwp_warn_if.latch w // warning carrier
);
  import dwp_pkg::*;
  localparam dwp_warn_t AUTO = `DWP_WARN_AUTO_MASK;
  dwp_warn_t live_reg, live_next, latched_reg, latched_next;

  // per bit: self-clearing bits follow the condition, others stick
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_bit
      assign latched_next[i] = AUTO[i] ? w.cond[i] // [RULE6]
          : ((w.fault_reset ? 1'b0 : latched_reg[i]) | w.cond[i]); // [RULE4] [RULE5] [RULE12]
    end
  endgenerate

  // live word is the condition itself
  always_comb begin
    live_next = w.cond; // [RULE3]
  end

  // register both words
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      live_reg <= `DWP_RST_WARN;
      latched_reg <= `DWP_RST_WARN;
    end else begin
      live_reg <= live_next;
      latched_reg <= latched_next;
    end
  end

  assign w.live = live_reg;
  assign w.latched = latched_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_sticky_set: assert property (w.cond[0] |=> w.latched[0] && w.live[0]) // [RULE12]
    else $error("sticky bit not set with live bit");
  a_sticky_hold: assert property (w.latched[4] && !w.fault_reset && !w.cond[4]
      |=> w.latched[4]) // [RULE4]
    else $error("sticky bit lost without fault reset");
  a_fault_clear: assert property (w.fault_reset && w.cond == 16'h0000
      |=> w.latched == 16'h0000) // [RULE5]
    else $error("fault reset left sticky bits");
  a_fault_set_wins: assert property (w.fault_reset && w.cond[1] |=> w.latched[1]) // [RULE12]
    else $error("fault reset beat a live warning");
  a_auto_clear: assert property (w.latched[13] && !w.cond[13] |=> !w.latched[13]) // [RULE6]
    else $error("self-clearing bit stayed set");
endmodule : dwp_warn_latch

// file: logic/dwp_param_bank.sv
/*
  parameter bank: four user storage words, homing gate for absolute moves,
  live and sticky warning words and the bus voltage usage readout.
  assumes a single-master parameter access port synchronous to sys_clk;
  non-volatile backing of persistent values is kept outside this block.
*/
`timescale 1ns/1ps
`include "dwp_cfg.svh"

// What this block does
// RULE1 - four 32-bit read/write user words, factory zero, persistent
// RULE2 - read-only signed 16-bit bus voltage usage, 100 means limit
// RULE3 - read-only live word of active class 0 warnings, same bits
// RULE4 - read-only sticky word; bit is 1 once its warning occurred
// RULE5 - fault reset clears every sticky warning bit
// RULE6 - sticky bits 10, 11, 13 clear themselves when condition ends
// RULE7 - bits 0 general, 1 stage temp, 2 motor temp, 4, 6; 3, 5, 15 reserved
// RULE8 - bits 7 CAN, 8 encoder, 9 RS485, 12 fieldbus, 14 Ethernet
// RULE9 - bits 10 safe torque off, 11 undervoltage, 13 position not valid
// RULE10 - homing flag 1 refuses absolute moves until homed; factory 0
// RULE11 - homing flag write acts at once
// RULE12 - sticky bit sets with its live bit and holds until cleared
module dwp_param_bank (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic acc_req, // access request, one cycle
  input wire logic acc_we, // 1 write, 0 read
  input wire dwp_pkg::dwp_addr_t acc_addr, // parameter address
  input wire dwp_pkg::dwp_word_t acc_wdata, // write data, low bits for 16-bit
  output dwp_pkg::dwp_word_t acc_rdata, // read data, registered
  output logic acc_ack, // answer pulse
  output logic acc_err, // refused access, with ack
  input wire dwp_pkg::dwp_warn_t warn_cond, // raw warning conditions
  input wire logic fault_reset, // fault reset command pulse
  input wire dwp_pkg::dwp_pct_t volt_use_in, // measured bus voltage usage
  input wire logic homing_done, // homing has completed
  input wire logic abs_move_req, // absolute move requested
  output logic abs_move_ok, // absolute move may start
  output logic abs_home_flag // current homing flag
);
  import dwp_pkg::*;

  dwp_warn_if wif ();
  dwp_word_t user_reg [4];
  dwp_word_t user_next [4];
  logic abs_home_reg, abs_home_next;
  dwp_pct_t volt_reg, volt_next;
  dwp_state_t state_reg, state_next;
  dwp_word_t rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic hit, ro_hit, bad_val;
  logic [1:0] user_idx;
  logic user_hit;
  dwp_word_t rd_mux;

  // warning conditions: undefined bits forced low
  assign wif.cond = warn_cond & `DWP_WARN_VALID_MASK; // [RULE7] [RULE8] [RULE9]
  assign wif.fault_reset = fault_reset;

  dwp_warn_latch u_latch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .w(wif.latch)
  );

  // address decode and read multiplexer
  always_comb begin
    user_hit = 1'b0;
    user_idx = 2'd0;
    ro_hit = 1'b0;
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (acc_addr)
      `DWP_OFS_USER_A: begin
        user_hit = 1'b1;
        user_idx = 2'd0;
      end
      `DWP_OFS_USER_B: begin
        user_hit = 1'b1;
        user_idx = 2'd1;
      end
      `DWP_OFS_USER_C: begin
        user_hit = 1'b1;
        user_idx = 2'd2;
      end
      `DWP_OFS_USER_D: begin
        user_hit = 1'b1;
        user_idx = 2'd3;
      end
      `DWP_OFS_ABS_HOME: begin
        rd_mux = {31'h0000_0000, abs_home_reg};
      end
      `DWP_OFS_LIVE_WARN: begin
        ro_hit = 1'b1;
        rd_mux = {16'h0000, wif.live}; // [RULE3]
      end
      `DWP_OFS_STICKY_WARN: begin
        ro_hit = 1'b1;
        rd_mux = {16'h0000, wif.latched}; // [RULE4]
      end
      `DWP_OFS_VOLT_USE: begin
        ro_hit = 1'b1;
        rd_mux = {{16{volt_reg[15]}}, volt_reg}; // [RULE2]
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (user_hit) begin
      rd_mux = user_reg[user_idx];
    end
  end

  // homing flag accepts only 0 or 1
  assign bad_val = (acc_addr == `DWP_OFS_ABS_HOME) && (acc_wdata > `DWP_ABS_HOME_MAX);

  // next values of the stored parameters
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      user_next[k] = user_reg[k];
    end
    abs_home_next = abs_home_reg;
    volt_next = volt_use_in; // [RULE2]
    if (acc_req && acc_we && hit && !ro_hit && !bad_val) begin
      if (user_hit) begin
        user_next[user_idx] = acc_wdata; // [RULE1]
      end else begin
        abs_home_next = acc_wdata[0]; // [RULE10]
      end
    end
  end

  // register the stored parameters
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) begin
        user_reg[k] <= `DWP_RST_USER; // [RULE1]
      end
      abs_home_reg <= `DWP_RST_ABS_HOME; // [RULE10]
      volt_reg <= 16'sh0000;
    end else begin
      for (int k = 0; k < 4; k++) begin
        user_reg[k] <= user_next[k];
      end
      abs_home_reg <= abs_home_next;
      volt_reg <= volt_next;
    end
  end

  // access answer: one cycle after the request
  always_comb begin
    state_next = DWP_IDLE;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    unique case (state_reg)
      DWP_IDLE, DWP_ANSWER: begin
        if (acc_req) begin
          state_next = DWP_ANSWER;
          err_next = !hit || (acc_we && (ro_hit || bad_val));
          rdata_next = (acc_we || !hit) ? 32'h0000_0000 : rd_mux;
        end
      end
      default: begin
        state_next = DWP_IDLE;
      end
    endcase
  end

  // register the answer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= DWP_IDLE;
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign acc_ack = (state_reg == DWP_ANSWER);
  assign acc_err = acc_ack && err_reg;
  assign acc_rdata = rdata_reg;
  // gate acts on the stored flag, so a write counts from the next cycle
  assign abs_move_ok = abs_move_req && (!abs_home_reg || homing_done); // [RULE10] [RULE11]
  assign abs_home_flag = abs_home_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_user_write;
    acc_req && acc_we && acc_addr == `DWP_OFS_USER_B;
  endsequence
  sequence s_read_back;
    acc_req && !acc_we && acc_addr == `DWP_OFS_USER_B;
  endsequence
  sequence s_flag_set;
    acc_req && acc_we && acc_addr == `DWP_OFS_ABS_HOME && acc_wdata == 32'h0000_0001;
  endsequence

  a_user_store: assert property (s_user_write ##1 !acc_req ##1 s_read_back // [RULE1]
      |=> acc_ack && acc_rdata == $past(acc_wdata, 3))
    else $error("user word did not read back");
  a_flag_immediate: assert property (s_flag_set ##1 (!homing_done && abs_move_req) // [RULE11]
      |-> !abs_move_ok)
    else $error("homing flag not effective at once");
  a_abs_free: assert property (!abs_home_reg && abs_move_req |-> abs_move_ok) // [RULE10]
    else $error("absolute move refused with flag clear");
  a_ro_refused: assert property (acc_req && acc_we && acc_addr == `DWP_OFS_STICKY_WARN // [RULE4]
      |=> acc_ack && acc_err)
    else $error("write to read-only word not refused");
  a_volt_read: assert property (acc_req && !acc_we && acc_addr == `DWP_OFS_VOLT_USE // [RULE2]
      |=> acc_rdata[15:0] == $past(volt_reg))
    else $error("voltage usage read wrong");
  a_reserved_zero: assert property (##1 wif.latched[3] == 1'b0 // [RULE7]
      && wif.latched[15] == 1'b0 && wif.live[5] == 1'b0)
    else $error("reserved warning bit set");
  a_live_read: assert property (acc_req && !acc_we && acc_addr == `DWP_OFS_LIVE_WARN // [RULE3]
      |=> acc_rdata == {16'h0000, $past(wif.live)})
    else $error("live warning read wrong");
  a_ack_once: assert property (acc_req |=> acc_ack) // [RULE1]
    else $error("access not answered");
endmodule : dwp_param_bank

// file: testbench/dwp_master_model.sv
/*
  fieldbus master model: one parameter access at a time.
  assumes the task is called at a rising edge of sys_clk; answer comes next cycle.
*/
`timescale 1ns/1ps
module dwp_master_model (
  input wire logic sys_clk, // system clock
  output logic acc_req, // access request pulse
  output logic acc_we, // 1 write, 0 read
  output dwp_pkg::dwp_addr_t acc_addr, // parameter address
  output dwp_pkg::dwp_word_t acc_wdata, // write data
  input wire dwp_pkg::dwp_word_t acc_rdata, // read data
  input wire logic acc_ack, // answer pulse
  input wire logic acc_err // refusal flag
);
  import dwp_pkg::*;
  // idle lines at time zero
  initial begin
    acc_req = 1'h0;
    acc_we = 1'h0;
    acc_addr = 16'hFFFF;
    acc_wdata = 32'hA5A5_5A5A;
  end
  // one-cycle request, then wait a bounded time for the answer
  task automatic access(input logic we, input dwp_addr_t a, input dwp_word_t d,
                        output dwp_word_t rd, output logic er);
    int n;
    acc_req <= 1'h1;
    acc_we <= we;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge sys_clk);
    acc_req <= 1'h0;
    acc_we <= ~we; // released lines never keep the old value
    acc_addr <= ~a;
    acc_wdata <= ~d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (acc_ack !== 1'h1 && n < 4);
    rd = acc_rdata;
    er = (acc_ack === 1'h1) ? acc_err : 1'bx; // no answer gives unknown
  endtask : access
endmodule : dwp_master_model

// file: testbench/dwp_param_bank_tb.sv
/*
  self-checking bench for the parameter bank.
  assumes dwp_cfg.svh on the include path and the master model alongside.
*/
`timescale 1ns/1ps
`include "dwp_cfg.svh"
module dwp_param_bank_tb;
  import dwp_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic fault_reset = 1'h0;
  logic homing_done = 1'h0;
  logic abs_move_req = 1'h0;
  dwp_warn_t warn_cond = 16'h0000;
  dwp_pct_t volt_use_in = 16'h0000;
  logic acc_req, acc_we, acc_ack, acc_err, abs_move_ok, abs_home_flag;
  dwp_addr_t acc_addr;
  dwp_word_t acc_rdata, acc_wdata, w;
  dwp_warn_t c;
  dwp_pct_t v;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam dwp_addr_t ADR[8] = '{`DWP_OFS_USER_A, `DWP_OFS_USER_B, `DWP_OFS_USER_C,
    `DWP_OFS_USER_D, `DWP_OFS_ABS_HOME, `DWP_OFS_LIVE_WARN, `DWP_OFS_STICKY_WARN,
    `DWP_OFS_VOLT_USE};

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  dwp_param_bank i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .acc_req(acc_req),
    .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_ack(acc_ack), .acc_err(acc_err), .warn_cond(warn_cond),
    .fault_reset(fault_reset), .volt_use_in(volt_use_in), .homing_done(homing_done),
    .abs_move_req(abs_move_req), .abs_move_ok(abs_move_ok),
    .abs_home_flag(abs_home_flag));

  dwp_master_model i_mst (.sys_clk(sys_clk), .acc_req(acc_req), .acc_we(acc_we),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_ack(acc_ack), .acc_err(acc_err));

  // sticky value expected once the conditions have gone away
  function automatic dwp_word_t sticky_left(input dwp_warn_t cv);
    return {16'h0000, cv & `DWP_WARN_VALID_MASK & ~`DWP_WARN_AUTO_MASK};
  endfunction : sticky_left

  // compare and count
  task automatic check(input dwp_word_t seen, input dwp_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one access with expected refusal flag and, for reads, expected data
  task automatic acc(input logic we, input dwp_addr_t a, input dwp_word_t d,
                     input dwp_word_t e, input logic ee);
    dwp_word_t rd;
    logic er;
    i_mst.access(we, a, d, rd, er);
    check({31'h0, er}, {31'h0, ee});
    if (!we) check(rd, e);
  endtask : acc

  // closing report
  task give_verdict;
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  // main sequence
  initial begin
    void'($urandom(55));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    // factory values of every word
    foreach (ADR[i]) acc(1'h0, ADR[i], 0, 0, 1'h0);
    // user words, odd neighbours unmapped
    for (int i = 0; i < 4; i++) begin
      w = $urandom();
      acc(1'h1, ADR[i], w, 0, 1'h0);
      acc(1'h0, ADR[i], 0, w, 1'h0);
      acc(1'h0, ADR[i] + 16'h0001, 0, 0, 1'h1);
    end
    // read-only words refuse writes
    for (int i = 5; i < 8; i++) acc(1'h1, ADR[i], 32'h0000_FFFF, 0, 1'h1);
    // voltage usage: limit value, negative, random
    for (int i = 0; i < 6; i++) begin
      v = dwp_pct_t'($urandom());
      if (i == 0) v = 16'h0064;
      if (i == 1) v = 16'hFFFF;
      volt_use_in <= v;
      repeat (2) @(posedge sys_clk);
      acc(1'h0, `DWP_OFS_VOLT_USE, 0, {{16{v[15]}}, v}, 1'h0);
    end
    // warnings one bit at a time, then random mixes
    for (int i = 0; i < 20; i++) begin
      c = (i < 16) ? 16'h0001 << i : dwp_warn_t'($urandom());
      w = {16'h0000, c & `DWP_WARN_VALID_MASK};
      warn_cond <= c;
      repeat (2) @(posedge sys_clk);
      acc(1'h0, `DWP_OFS_LIVE_WARN, 0, w, 1'h0);
      acc(1'h0, `DWP_OFS_STICKY_WARN, 0, w, 1'h0);
      // fault reset while the conditions stand: the set wins
      fault_reset <= 1'h1;
      @(posedge sys_clk);
      fault_reset <= 1'h0;
      acc(1'h0, `DWP_OFS_STICKY_WARN, 0, w, 1'h0);
      warn_cond <= 16'h0000;
      repeat (2) @(posedge sys_clk);
      acc(1'h0, `DWP_OFS_STICKY_WARN, 0, sticky_left(c), 1'h0);
      fault_reset <= 1'h1;
      @(posedge sys_clk);
      fault_reset <= 1'h0;
      @(posedge sys_clk);
      acc(1'h0, `DWP_OFS_STICKY_WARN, 0, 0, 1'h0);
    end
    // homing gate for absolute moves
    abs_move_req <= 1'h1;
    acc(1'h1, `DWP_OFS_ABS_HOME, 1, 0, 1'h0);
    check({31'h0, abs_home_flag}, 1);
    check({31'h0, abs_move_ok}, 0);
    acc(1'h0, `DWP_OFS_ABS_HOME, 0, 1, 1'h0);
    homing_done <= 1'h1;
    @(posedge sys_clk);
    check({31'h0, abs_move_ok}, 1);
    homing_done <= 1'h0;
    acc(1'h1, `DWP_OFS_ABS_HOME, 2, 0, 1'h1);
    check({31'h0, abs_move_ok}, 0);
    acc(1'h1, `DWP_OFS_ABS_HOME, 0, 0, 1'h0);
    check({31'h0, abs_move_ok}, 1);
    acc(1'h1, `DWP_OFS_ABS_HOME, 1, 0, 1'h0);
    // mid-run reset brings every word back to its factory value
    rst_n <= 1'h0;
    volt_use_in <= 16'h0000;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    foreach (ADR[i]) acc(1'h0, ADR[i], 0, 0, 1'h0);
    give_verdict();
  end
endmodule : dwp_param_bank_tb
